/* ast_gate.sv */
`timescale 1ns/1ps
module ast_gate
   import ast_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          gp_line_in,
   input  wire logic [2:0]    cc_line_in,
   input  wire logic          frame_trig_in,
   output logic               frame_start_out,
   output logic               acq_waiting,
   output logic               frame_waiting,
   output logic               gp_pin_direction
);

   ast_edge_if edge_bus ();

   logic [5:0]       ctrl_ff;
   logic [5:0]       nxt_ctrl;
   logic [7:0]       burst_ff;
   logic [7:0]       nxt_burst;
   logic             fire_ff;
   logic             nxt_fire;
   logic [31:0]      prdata_ff;
   logic [31:0]      nxt_prdata;
   logic             pready_ff;
   logic             nxt_pready;
   logic             pslverr_ff;
   logic             nxt_pslverr;
   ast_state_type    state_ff;
   ast_state_type    nxt_state;
   logic [7:0]       cnt_ff;
   logic [7:0]       nxt_cnt;
   logic             frame_start_ff;
   logic             nxt_frame_start;
   logic             acq_wait_ff;
   logic             frame_wait_ff;
   logic             gate_en;
   logic [2:0]       src_sel;
   logic             start_evt;
   logic             wr_take;
   logic             wr_fire;
   logic             hit;
   logic [3:0]       ofs;
   logic [8:0]       cnt_plus;

   assign gate_en = ctrl_ff[AST_CTRL_EN_BIT];
   assign src_sel = ctrl_ff[AST_CTRL_SRC_MSB:AST_CTRL_SRC_LSB];
   assign ofs     = paddr[AST_AW-1:0];
   assign hit     = (paddr[11:AST_AW] == 8'h00);

   // A write lands only at the edge where the access phase sees pready.
   assign wr_take = psel & penable & pready_ff & pwrite;
   assign wr_fire = wr_take & hit & (ofs == AST_FIRE_OFS) & pwdata[0];

   // Edge selector gets the raw pins; it owns their synchronisers.
   assign edge_bus.hw_lines    = {cc_line_in, gp_line_in};
   assign edge_bus.src_sel     = src_sel;
   assign edge_bus.fall_pol    = ctrl_ff[AST_CTRL_POL_BIT];
   assign edge_bus.gp_is_input = ctrl_ff[AST_CTRL_DIR_BIT];

   ast_edge_sel #(
      .NUM_LINES (AST_NUM_LINES)
   ) u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .ifc     (edge_bus)
   );

   // Exactly one origin feeds the start event; unused codes give none.
   always_comb begin
      start_evt = 1'b0;
      if (src_sel == AST_SRC_SW) begin
         start_evt = fire_ff;
      end else if (src_sel <= AST_SRC_CC3) begin
         start_evt = edge_bus.start_pulse;
      end
   end

   // APB next values; every access takes one wait cycle, so pready is
   // registered and the read data is ready in the same cycle.
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_burst   = burst_ff;
      nxt_pready  = psel & penable & ~pready_ff;
      nxt_prdata  = prdata_ff;
      nxt_pslverr = 1'b0;
      // A fire write always wins over the self-clear.
      nxt_fire    = wr_fire;
      if (nxt_pready) begin
         nxt_prdata = 32'h0000_0000;
         if (!hit) begin
            nxt_pslverr = 1'b1;
         end else if (ofs == AST_CTRL_OFS) begin
            nxt_prdata[5:0] = ctrl_ff;
         end else if (ofs == AST_BURST_OFS) begin
            nxt_prdata[7:0] = burst_ff;
         end else if (ofs == AST_FIRE_OFS) begin
            nxt_prdata[0] = fire_ff;
         end else if (ofs == AST_STATUS_OFS) begin
            nxt_prdata[AST_STS_ACQ_BIT] = acq_wait_ff;
            nxt_prdata[AST_STS_FRM_BIT] = frame_wait_ff;
            nxt_prdata[AST_STS_CNT_MSB:AST_STS_CNT_LSB] = cnt_ff;
         end else begin
            nxt_pslverr = 1'b1;
         end
      end
      if (wr_take && hit) begin
         if (ofs == AST_CTRL_OFS) begin
            nxt_ctrl = pwdata[5:0];
         end else if (ofs == AST_BURST_OFS) begin
            // Zero is outside the legal range and is dropped.
            if (pwdata[7:0] >= AST_BURST_MIN) begin
               nxt_burst = pwdata[7:0];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff    <= AST_CTRL_RST;
         burst_ff   <= AST_BURST_RST;
         fire_ff    <= 1'b0;
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         burst_ff   <= nxt_burst;
         fire_ff    <= nxt_fire;
         pready_ff  <= nxt_pready;
         prdata_ff  <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign cnt_plus = {1'b0, cnt_ff} + 9'h001;

   // Gate state machine. The count is compared with at-least so that a
   // burst lowered mid-burst still ends the burst instead of wrapping.
   always_comb begin
      nxt_state       = state_ff;
      nxt_cnt         = cnt_ff;
      nxt_frame_start = 1'b0;
      case (state_ff)
         AST_ST_OFF: begin
            // Start events are internal here, so every trigger passes.
            nxt_frame_start = frame_trig_in;
            if (gate_en) begin
               nxt_state = AST_ST_WAIT_ACQ;
               nxt_cnt   = 8'h00;
            end
         end
         AST_ST_WAIT_ACQ: begin
            // Frame triggers are dropped here.
            nxt_frame_start = 1'b0;
            if (start_evt) begin
               nxt_state = AST_ST_WAIT_FRAME;
               nxt_cnt   = 8'h00;
            end
         end
         AST_ST_WAIT_FRAME: begin
            nxt_frame_start = frame_trig_in;
            if (frame_trig_in) begin
               nxt_cnt = cnt_plus[7:0];
               if (cnt_plus >= {1'b0, burst_ff}) begin
                  nxt_state = AST_ST_WAIT_ACQ;
                  nxt_cnt   = 8'h00;
               end
            end
         end
         default: begin
            nxt_state = AST_ST_OFF;
         end
      endcase
      if (!gate_en) begin
         nxt_state = AST_ST_OFF;
         nxt_cnt   = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff       <= AST_ST_OFF;
         cnt_ff         <= 8'h00;
         frame_start_ff <= 1'b0;
         acq_wait_ff    <= 1'b0;
         frame_wait_ff  <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         cnt_ff         <= nxt_cnt;
         frame_start_ff <= nxt_frame_start;
         acq_wait_ff    <= (nxt_state == AST_ST_WAIT_ACQ);
         frame_wait_ff  <= (nxt_state == AST_ST_WAIT_FRAME);
      end
   end

   // All outputs are flip-flops.
   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign frame_start_out  = frame_start_ff;
   assign acq_waiting      = acq_wait_ff;
   assign frame_waiting    = frame_wait_ff;
   assign gp_pin_direction = ctrl_ff[AST_CTRL_DIR_BIT];

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wait_blocks_a: assert property (
      (state_ff == AST_ST_WAIT_ACQ) && frame_trig_in |=> !frame_start_out)
      else $error("Frame trigger passed while waiting for start.");
   enable_arms_a: assert property (
      (state_ff == AST_ST_OFF) && gate_en |=> acq_waiting && !frame_waiting)
      else $error("Enabling the gate did not arm it.");
   start_opens_a: assert property (
      (state_ff == AST_ST_WAIT_ACQ) && start_evt && gate_en
      |=> frame_waiting ##0 (cnt_ff == 8'h00))
      else $error("Start event did not open the frame state.");
   burst_ends_a: assert property (
      (state_ff == AST_ST_WAIT_FRAME) && gate_en && frame_trig_in &&
      (cnt_plus >= {1'b0, burst_ff}) |=> acq_waiting ##0 frame_start_out)
      else $error("Burst did not end at the programmed count.");
   rearm_needed_a: assert property (
      (state_ff == AST_ST_WAIT_ACQ) && !start_evt |=> !frame_waiting)
      else $error("Frame state entered without a start event.");
   fire_starts_a: assert property (
      (state_ff == AST_ST_WAIT_ACQ) && gate_en && (src_sel == AST_SRC_SW)
      && fire_ff |=> frame_waiting)
      else $error("Software fire did not start acquisition.");
   hw_ignores_fire_a: assert property (
      (state_ff == AST_ST_WAIT_ACQ) && (src_sel != AST_SRC_SW) &&
      !edge_bus.start_pulse |=> !frame_waiting)
      else $error("Start taken from an unselected origin.");
   fire_clears_a: assert property (
      wr_fire |=> fire_ff ##1 !fire_ff)
      else $error("Fire register did not self-clear.");
   burst_legal_a: assert property (
      burst_ff != 8'h00)
      else $error("Burst setting left the legal range.");
   off_passes_a: assert property (
      (state_ff == AST_ST_OFF) && frame_trig_in |=> frame_start_out)
      else $error("Frame trigger lost with the gate off.");

   burst_done_c: cover property (
      frame_waiting ##1 acq_waiting && $past(frame_start_out));
   sw_start_c: cover property (
      fire_ff && (src_sel == AST_SRC_SW) && (state_ff == AST_ST_WAIT_ACQ));
   hw_start_c: cover property (
      edge_bus.start_pulse && (state_ff == AST_ST_WAIT_ACQ));
   bad_addr_c: cover property (pready && pslverr);

endmodule

/* ast_pkg.sv */
// What this block does
// - Gate on: start waiting, ignore frame triggers.
// - Start event moves to waiting-for-frame state.
// - Count frames; at burst count re-arm.
// - Each new burst needs fresh start event.
// - Start taken from exactly one selected origin.
// - Software origin: each fire is one event.
// - CC origin: use edges of the selected polarity on that line.
// - Rising polarity: only low-to-high transitions count.
// - Falling polarity: only high-to-low transitions count.
// - Burst setting holds values 1 to 255.
// - Gate off: start events generated internally.
// - Discard frame triggers in waiting-for-start state.
// - Fire register issues one event, self-clears.
package ast_pkg;

   // Register byte offsets.
   localparam int unsigned   AST_AW          = 4;
   localparam logic [3:0]    AST_CTRL_OFS    = 4'h0;
   localparam logic [3:0]    AST_BURST_OFS   = 4'h4;
   localparam logic [3:0]    AST_FIRE_OFS    = 4'h8;
   localparam logic [3:0]    AST_STATUS_OFS  = 4'hc;

   // Control register field positions.
   localparam int unsigned   AST_CTRL_EN_BIT   = 0;
   localparam int unsigned   AST_CTRL_SRC_LSB  = 1;
   localparam int unsigned   AST_CTRL_SRC_MSB  = 3;
   localparam int unsigned   AST_CTRL_POL_BIT  = 4;
   localparam int unsigned   AST_CTRL_DIR_BIT  = 5;

   // Status register field positions.
   localparam int unsigned   AST_STS_ACQ_BIT   = 0;
   localparam int unsigned   AST_STS_FRM_BIT   = 1;
   localparam int unsigned   AST_STS_CNT_LSB   = 8;
   localparam int unsigned   AST_STS_CNT_MSB   = 15;

   // Origin encodings of the control source field.
   localparam logic [2:0]    AST_SRC_SW      = 3'h0;
   localparam logic [2:0]    AST_SRC_GP      = 3'h1;
   localparam logic [2:0]    AST_SRC_CC1     = 3'h2;
   localparam logic [2:0]    AST_SRC_CC2     = 3'h3;
   localparam logic [2:0]    AST_SRC_CC3     = 3'h4;

   // Reset values and the smallest legal burst.
   localparam logic [5:0]    AST_CTRL_RST    = 6'h00;
   localparam logic [7:0]    AST_BURST_RST   = 8'h01;
   localparam logic [7:0]    AST_BURST_MIN   = 8'h01;

   // Number of hardware trigger lines: the GP pin and three CC lines.
   localparam int unsigned   AST_NUM_LINES   = 4;

   typedef enum logic [1:0] {
      AST_ST_OFF,
      AST_ST_WAIT_ACQ,
      AST_ST_WAIT_FRAME
   } ast_state_type;

endpackage

/* ast_edge_if.sv */
`timescale 1ns/1ps
// Carries raw trigger lines, selection and the qualified start pulse.
interface ast_edge_if;
   logic [3:0]    hw_lines;
   logic [2:0]    src_sel;
   logic          fall_pol;
   logic          gp_is_input;
   logic          start_pulse;

   modport core (
      output hw_lines,
      output src_sel,
      output fall_pol,
      output gp_is_input,
      input  start_pulse
   );

   modport edge_end (
      input  hw_lines,
      input  src_sel,
      input  fall_pol,
      input  gp_is_input,
      output start_pulse
   );
endinterface

/* ast_edge_sel.sv */
`timescale 1ns/1ps
module ast_edge_sel
   import ast_pkg::*;
#(
   parameter int unsigned NUM_LINES = AST_NUM_LINES
) (
   input  wire logic   pclk,
   input  wire logic   presetn,
   ast_edge_if.edge_end ifc
);

   // The carrier has exactly four line wires, so other counts are refused.
   if (NUM_LINES != AST_NUM_LINES) begin : g_bad_lines
      $error("ast_edge_sel serves exactly four trigger lines.");
   end

   logic [NUM_LINES-1:0] meta_ff;
   logic [NUM_LINES-1:0] sync_ff;
   logic [NUM_LINES-1:0] prev_ff;
   logic [NUM_LINES-1:0] edge_hit;
   logic                 pulse_ff;
   logic                 nxt_pulse;
   logic                 line_ok;

   // Per line: two-stage synchroniser, a history stage and an edge test.
   // Edges are found per line before selection, so switching the origin
   // cannot fake an edge out of two different lines.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
               prev_ff[gi] <= 1'b0;
            end else begin
               meta_ff[gi] <= ifc.hw_lines[gi];
               sync_ff[gi] <= meta_ff[gi];
               prev_ff[gi] <= sync_ff[gi];
            end
         end
         // Falling polarity looks for high-to-low, rising for low-to-high.
         assign edge_hit[gi] = ifc.fall_pol ?
                               (prev_ff[gi] & ~sync_ff[gi]) :
                               (~prev_ff[gi] & sync_ff[gi]);
      end
   endgenerate

   // Only the selected hardware origin may raise the pulse.
   always_comb begin
      line_ok   = 1'b0;
      nxt_pulse = 1'b0;
      if (ifc.src_sel == AST_SRC_GP) begin
         line_ok   = ifc.gp_is_input;
         nxt_pulse = edge_hit[0] & line_ok;
      end else if (ifc.src_sel == AST_SRC_CC1) begin
         nxt_pulse = edge_hit[1];
      end else if (ifc.src_sel == AST_SRC_CC2) begin
         nxt_pulse = edge_hit[2];
      end else if (ifc.src_sel == AST_SRC_CC3) begin
         nxt_pulse = edge_hit[3];
      end
   end

   // Registered pulse, one cycle per qualified transition.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= nxt_pulse;
      end
   end

   assign ifc.start_pulse = pulse_ff;

   single_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_ff |=> !pulse_ff) else $error("Start pulse longer than one cycle.");
   rising_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ifc.src_sel == AST_SRC_CC1) && !ifc.fall_pol && !prev_ff[1] && sync_ff[1]
      |=> pulse_ff) else $error("Rising edge on CC1 missed.");
   falling_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ifc.src_sel == AST_SRC_CC2) && ifc.fall_pol && prev_ff[2] && sync_ff[2]
      |=> !pulse_ff) else $error("Pulse without falling edge on CC2.");

endmodule

/* ast_grab_model.sv */
`timescale 1ns/1ps
// Far side of the trigger lines: [0] is the GP pin source, [3:1] are the
// frame grabber outputs on CC1..CC3.
module ast_grab_model #(
   parameter int HOLD = 4
) (
   input  wire logic       pclk,
   input  wire logic [3:0] rest_lvl,
   input  wire logic [3:0] pulse_req,
   output logic      [3:0] lines
);
   logic [3:0] act_ff = 4'h0;
   int         cnt_ff = 0;

   // A request swings the lines off rest for HOLD cycles; a shorter swing
   // could slip between two samples of the synchroniser.
   always_ff @(posedge pclk) begin
      if (pulse_req != 4'h0) begin
         act_ff <= pulse_req;
         cnt_ff <= HOLD;
      end else if (cnt_ff > 1) begin
         cnt_ff <= cnt_ff - 1;
      end else begin
         act_ff <= 4'h0;
      end
   end

   // The grabber drives its lines at all times, so no released state.
   assign lines = rest_lvl ^ act_ff;
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
   import ast_pkg::*;
   typedef struct packed {
      logic [2:0] src;
      logic       pol;
      logic       dir;
      logic [7:0] burst;
      logic       go;
   } ast_row_type;
   localparam logic [11:0] CTRL_A  = {8'h00, AST_CTRL_OFS};
   localparam logic [11:0] BURST_A = {8'h00, AST_BURST_OFS};
   localparam logic [11:0] FIRE_A  = {8'h00, AST_FIRE_OFS};
   localparam logic [11:0] STS_A   = {8'h00, AST_STATUS_OFS};
   // Origin, polarity, pin direction, burst, start expected.
   localparam ast_row_type ROWS [5] = '{
      '{AST_SRC_CC1, 1'b0, 1'b0, 8'h01, 1'b1},
      '{AST_SRC_CC2, 1'b1, 1'b0, 8'h02, 1'b1},
      '{AST_SRC_CC3, 1'b0, 1'b0, 8'h03, 1'b1},
      '{AST_SRC_GP,  1'b1, 1'b1, 8'h01, 1'b1},
      '{AST_SRC_GP,  1'b0, 1'b0, 8'h01, 1'b0}};
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic        pready, pslverr, rd_err, gp_line_in, frame_trig_in;
   logic        frame_start_out, acq_waiting, frame_waiting, gp_dir;
   logic [2:0]  cc_line_in;
   logic [3:0]  rest_lvl, pulse_req, lines, m;
   int          fail_count, n_tests, cyc;

   ast_gate ast_gate_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gp_line_in(gp_line_in), .cc_line_in(cc_line_in),
      .frame_trig_in(frame_trig_in), .frame_start_out(frame_start_out),
      .acq_waiting(acq_waiting), .frame_waiting(frame_waiting),
      .gp_pin_direction(gp_dir));
   ast_grab_model ast_grab_model_i (.pclk(pclk), .rest_lvl(rest_lvl),
      .pulse_req(pulse_req), .lines(lines));

   // Split the far-side lines onto the GP pin and the CC inputs.
   assign gp_line_in = lines[0];
   assign cc_line_in = lines[3:1];

   // Free-running 10 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string s);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   // One APB transfer; a dead slave is caught by the cycle ceiling.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic trig(input logic exp, input string s);
      @(posedge pclk);
      frame_trig_in <= 1'b1;
      @(posedge pclk);
      frame_trig_in <= 1'b0;
      #1 chk(frame_start_out, exp, s);
   endtask

   task automatic pulse(input logic [3:0] p);
      @(posedge pclk);
      pulse_req <= p;
      @(posedge pclk);
      pulse_req <= 4'h0;
      tick(12);
   endtask

   task automatic print_verdict;
      $display("Compares %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // A run well past the expected few hundred cycles is a hang.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, frame_trig_in} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      rest_lvl = 4'h0;
      pulse_req = 4'h0;
      {fail_count, n_tests, cyc} = '0;
      tick(2);
      @(posedge pclk) presetn <= 1'b1;
      apb(1'b0, CTRL_A, 32'h0);
      chk(rd_data, 32'h0, "ctrl rst");
      apb(1'b0, BURST_A, 32'h0);
      chk(rd_data, 32'h1, "burst rst");
      $display("Test reset values done");
      foreach (ROWS[r]) begin
         m = (ROWS[r].src == AST_SRC_GP) ? 4'h1 :
             4'h1 << (ROWS[r].src - 3'h1);
         apb(1'b1, CTRL_A, 32'h0);
         @(posedge pclk) rest_lvl <= {4{~ROWS[r].pol}};
         tick(8);
         apb(1'b1, BURST_A, {24'h0, ROWS[r].burst});
         apb(1'b1, CTRL_A, {26'h0, ROWS[r].dir, ROWS[r].pol,
                            ROWS[r].src, 1'b1});
         tick(2);
         chk(acq_waiting, 1'b1, "armed");
         chk(gp_dir, ROWS[r].dir, "gp dir");
         trig(1'b0, "trig armed");
         @(posedge pclk) rest_lvl <= {4{ROWS[r].pol}};
         tick(10);
         chk(frame_waiting, 1'b0, "wrong edge");
         pulse(~m);
         chk(frame_waiting, 1'b0, "other line");
         apb(1'b1, FIRE_A, 32'h1);
         tick(3);
         chk(frame_waiting, 1'b0, "fire ignored");
         pulse(m);
         chk(frame_waiting, ROWS[r].go, "start");
         for (int i = 0; i < ROWS[r].burst; i++) begin
            trig(ROWS[r].go, "burst");
         end
         tick(2);
         chk(acq_waiting, 1'b1, "rearmed");
         trig(1'b0, "after burst");
         $display("Test row %0d done", r);
      end
      apb(1'b1, CTRL_A, 32'h0);
      apb(1'b1, BURST_A, 32'h2);
      apb(1'b1, CTRL_A, 32'h1);
      apb(1'b1, FIRE_A, 32'h1);
      apb(1'b0, FIRE_A, 32'h0);
      chk(rd_data, 32'h0, "fire clr");
      chk(frame_waiting, 1'b1, "sw start");
      trig(1'b1, "sw f1");
      apb(1'b0, STS_A, 32'h0);
      chk(rd_data, 32'h0102, "status");
      trig(1'b1, "sw f2");
      tick(2);
      chk(acq_waiting, 1'b1, "sw rearm");
      apb(1'b1, FIRE_A, 32'h1);
      tick(3);
      chk(frame_waiting, 1'b1, "fire again");
      apb(1'b1, BURST_A, 32'h0);
      apb(1'b0, BURST_A, 32'h0);
      chk(rd_data, 32'h2, "burst 0");
      apb(1'b1, BURST_A, 32'hff);
      apb(1'b0, BURST_A, 32'h0);
      chk(rd_data, 32'hff, "burst 255");
      apb(1'b0, 12'h010, 32'h0);
      chk(rd_err, 1'b1, "unmapped");
      apb(1'b1, CTRL_A, 32'h0);
      tick(2);
      chk(acq_waiting, 1'b0, "gate off");
      trig(1'b1, "off pass");
      apb(1'b1, CTRL_A, 32'h0000_000b);
      tick(2);
      chk(acq_waiting, 1'b1, "no origin armed");
      pulse(4'hf);
      apb(1'b1, FIRE_A, 32'h1);
      tick(3);
      chk(frame_waiting, 1'b0, "no origin");
      $display("Test software and registers done");
      apb(1'b1, CTRL_A, 32'h1);
      @(posedge pclk) presetn <= 1'b0;
      tick(2);
      chk(acq_waiting, 1'b0, "in reset");
      @(posedge pclk) presetn <= 1'b1;
      apb(1'b0, CTRL_A, 32'h0);
      chk(rd_data, 32'h0, "ctrl rerst");
      $display("Test mid-run reset done");
      print_verdict();
   end
endmodule
